// ---- sar_pkg.sv ----
// Purpose: Shared constants and types of the converter controller
// Assumes: APB with 32-bit data, byte addresses as printed
// Notes:   Own registers sit above the divider register
`default_nettype none
package sar_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_RESULT0  = 32'h5001_0D00;
  localparam logic [31:0] ADDR_TIMING   = 32'h5001_0D14;
  localparam logic [31:0] ADDR_FRONTEND = 32'h5001_0D18;
  localparam logic [31:0] ADDR_CONTROL  = 32'h5001_0D1C;
  localparam logic [31:0] ADDR_CHANNEL  = 32'h5001_0D20;
  localparam logic [31:0] ADDR_INTR     = 32'h5001_0D24;
  localparam logic [31:0] ADDR_CLKDIV   = 32'h5001_0D28;
  localparam logic [31:0] ADDR_RATE     = 32'h5001_0D2C;
  // Field positions
  localparam int POS_GAIN = 14, POS_MODE = 8, POS_FE_EN = 7, POS_EXT_CM = 0;
  localparam int POS_REPEAT = 18, POS_START = 16, POS_DIG_RST = 10, POS_CONV_EN = 0;
  localparam int POS_BATT = 31, POS_SLOT4 = 24, POS_SLOT3 = 16, POS_SLOT2 = 8, POS_SLOT1 = 3, POS_SEQLEN = 0;
  localparam int POS_IFLAG = 24, POS_DONE = 16, POS_ICLR = 8, POS_IENA = 0;
  localparam int POS_TDLY = 16, POS_TSEL = 8, POS_SAMP = 0;
  // Reset values
  localparam logic [1:0]  RST_GAIN   = 2'h1;
  localparam logic [1:0]  RST_MODE   = 2'h3;
  localparam logic [7:0]  RST_CLKDIV = 8'h05;
  localparam logic [3:0]  RST_TDLY   = 4'h8;
  localparam logic [3:0]  RST_SAMP   = 4'h7;
  localparam logic [3:0]  RST_TSEL   = 4'h0;
  localparam logic [15:0] RST_RATE   = 16'h0100;
  // Trigger sources
  localparam logic [3:0] TRIG_RATE = 4'h0;
  localparam logic [3:0] TRIG_SOFT = 4'h1;
  localparam logic [3:0] TRIG_RISE = 4'h2;
  localparam logic [3:0] TRIG_FALL = 4'h4;
  localparam logic [3:0] TRIG_PER  = 4'h8;
  localparam int NUM_SLOTS = 4;
  // Converter clock limit
  localparam int MCLK_HZ = 10_000_000;
  localparam int CONV_CLK_MAX_HZ = 4_000_000;
  localparam int MIN_CLKDIV = (MCLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_DELAY  = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_CONV   = 4'b1000
  } seq_state_e;

  typedef struct packed {
    logic [1:0] gain;
    logic [1:0] input_mode;
    logic       fe_enable;
    logic       ext_cm;
    logic       batt_scale;
    logic       conv_enable;
  } afe_cfg_s;
endpackage
`default_nettype wire

// ---- sar_adc_controller.sv ----
// Purpose: Sequencer, clock divider and APB registers of a SAR converter
// Assumes: Converter done and result arrive from the analog side unsynchronised
// Notes:   One APB wait state on every access
//
// Register access over APB was decided locally.
`default_nettype none
module sar_adc_controller
  import sar_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        PWM_RISE,
  input  wire logic        PWM_FALL,
  input  wire logic        PWM_PERIOD,
  input  wire logic        DONE_STATUS,
  input  wire logic [15:0] CONV_RESULT,
  output afe_cfg_s         AFE_CFG,
  output logic       [4:0] INPUT_SELECT,
  output logic             CONV_CLK,
  output logic             SAMPLE,
  output logic             CONV_START,
  output logic             DIG_RESET,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////
  // APB slave
  logic        setup_acc;
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [31:0] rdata;
  assign setup_acc = PSEL & PENABLE & ~PREADY;
  assign acc = PSEL & PENABLE & PREADY;
  assign wr = acc & PWRITE;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    return a == b;
  endfunction

  // Configuration registers
  logic [1:0]  gain_q, mode_q;
  logic        fe_en_q, ext_cm_q, repeat_q, conv_en_q, batt_q, iena_q;
  logic [4:0]  slot_sel_q [NUM_SLOTS];
  logic [2:0]  seqlen_q;
  logic [7:0]  clkdiv_q;
  logic [3:0]  tdly_q, tsel_q, samp_q;
  logic [15:0] rate_q;
  logic [15:0] result_q [NUM_SLOTS];
  logic        done_q, iflag_q, rate_run_q, dig_rst_q, iclr_q;
  seq_state_e  state_q;
  logic        busy;
  assign busy = (state_q != ST_IDLE) | rate_run_q;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      gain_q    <= RST_GAIN;
      mode_q    <= RST_MODE;
      fe_en_q   <= 1'b0;
      ext_cm_q  <= 1'b0;
      repeat_q  <= 1'b0;
      conv_en_q <= 1'b0;
      batt_q    <= 1'b0;
      seqlen_q  <= 3'h0;
      clkdiv_q  <= RST_CLKDIV;
      tdly_q    <= RST_TDLY;
      tsel_q    <= RST_TSEL;
      samp_q    <= RST_SAMP;
      rate_q    <= RST_RATE;
      iena_q    <= 1'b0;
    end else if (wr) begin
      if (hit(PADDR, ADDR_FRONTEND)) begin
        gain_q   <= PWDATA[POS_GAIN+:2];
        mode_q   <= PWDATA[POS_MODE+:2];
        fe_en_q  <= PWDATA[POS_FE_EN];
        ext_cm_q <= PWDATA[POS_EXT_CM];
      end
      if (hit(PADDR, ADDR_CONTROL)) begin
        repeat_q  <= PWDATA[POS_REPEAT];
        conv_en_q <= PWDATA[POS_CONV_EN];
      end
      if (hit(PADDR, ADDR_CHANNEL)) begin
        batt_q   <= PWDATA[POS_BATT];
        seqlen_q <= PWDATA[POS_SEQLEN+:3];
      end
      if (hit(PADDR, ADDR_TIMING)) begin
        tdly_q <= PWDATA[POS_TDLY+:4];
        tsel_q <= PWDATA[POS_TSEL+:4];
        samp_q <= PWDATA[POS_SAMP+:4];
      end
      if (hit(PADDR, ADDR_INTR)) begin
        iena_q <= PWDATA[POS_IENA];
      end
      if (hit(PADDR, ADDR_CLKDIV)) begin
        clkdiv_q <= PWDATA[7:0];
      end
      if (hit(PADDR, ADDR_RATE)) begin
        rate_q <= PWDATA[15:0];
      end
    end
  end

  // Slot input selects share one code table
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_sel_q[i] <= 5'h00;
      end
    end else if (wr && hit(PADDR, ADDR_CHANNEL)) begin
      slot_sel_q[0] <= PWDATA[POS_SLOT1+:5];
      slot_sel_q[1] <= PWDATA[POS_SLOT2+:5];
      slot_sel_q[2] <= PWDATA[POS_SLOT3+:5];
      slot_sel_q[3] <= PWDATA[POS_SLOT4+:5];
    end
  end

  // Self-clearing command pulses
  logic start_wr, start_one;
  assign start_wr = wr & hit(PADDR, ADDR_CONTROL);
  assign start_one = start_wr & PWDATA[POS_START];
  always_ff @(posedge MCLK) begin
    if (RST) begin
      dig_rst_q <= 1'b0;
      iclr_q    <= 1'b0;
    end else begin
      dig_rst_q <= start_wr & PWDATA[POS_DIG_RST];
      iclr_q    <= wr & hit(PADDR, ADDR_INTR) & PWDATA[POS_ICLR];
    end
  end

  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    if (PADDR[31:4] == ADDR_RESULT0[31:4] && PADDR[1:0] == 2'h0) begin
      rdata[15:0] = result_q[PADDR[3:2]];
    end else if (hit(PADDR, ADDR_TIMING)) begin
      rdata[POS_TDLY+:4] = tdly_q;
      rdata[POS_TSEL+:4] = tsel_q;
      rdata[POS_SAMP+:4] = samp_q;
    end else if (hit(PADDR, ADDR_FRONTEND)) begin
      rdata[POS_GAIN+:2] = gain_q;
      rdata[POS_MODE+:2] = mode_q;
      rdata[POS_FE_EN]   = fe_en_q;
      rdata[POS_EXT_CM]  = ext_cm_q;
    end else if (hit(PADDR, ADDR_CONTROL)) begin
      rdata[POS_REPEAT]  = repeat_q;
      rdata[POS_START]   = busy;
      rdata[POS_CONV_EN] = conv_en_q;
    end else if (hit(PADDR, ADDR_CHANNEL)) begin
      rdata[POS_BATT]     = batt_q;
      rdata[POS_SLOT4+:5] = slot_sel_q[3];
      rdata[POS_SLOT3+:5] = slot_sel_q[2];
      rdata[POS_SLOT2+:5] = slot_sel_q[1];
      rdata[POS_SLOT1+:5] = slot_sel_q[0];
      rdata[POS_SEQLEN+:3] = seqlen_q;
    end else if (hit(PADDR, ADDR_INTR)) begin
      rdata[POS_IFLAG] = iflag_q;
      rdata[POS_DONE]  = done_q;
      rdata[POS_IENA]  = iena_q;
    end else if (hit(PADDR, ADDR_CLKDIV)) begin
      rdata[7:0] = clkdiv_q;
    end else if (hit(PADDR, ADDR_RATE)) begin
      rdata[15:0] = rate_q;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup_acc;
      PSLVERR <= setup_acc & ~mapped;
      if (setup_acc && !PWRITE) begin
        PRDATA <= rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Converter clock divider
  logic [7:0] div_cnt_q;
  logic       tick;
  assign tick = (div_cnt_q >= clkdiv_q - 8'h01) | (clkdiv_q == 8'h00);
  always_ff @(posedge MCLK) begin
    if (RST || dig_rst_q || !conv_en_q) begin
      div_cnt_q <= 8'h00;
      CONV_CLK  <= 1'b0;
    end else begin
      div_cnt_q <= tick ? 8'h00 : div_cnt_q + 8'h01;
      CONV_CLK  <= (tick ? 8'h00 : div_cnt_q + 8'h01) < {1'b0, clkdiv_q[7:1]};
    end
  end

  // Rate generator for the rate trigger source
  logic [15:0] rate_cnt_q;
  logic        rate_tick;
  assign rate_tick = rate_run_q & (rate_cnt_q == 16'h0000);
  always_ff @(posedge MCLK) begin
    if (RST || dig_rst_q || !conv_en_q) begin
      rate_run_q <= 1'b0;
      rate_cnt_q <= 16'h0000;
    end else if (start_wr && tsel_q == TRIG_RATE) begin
      rate_run_q <= PWDATA[POS_START];
      rate_cnt_q <= rate_q;
    end else if (rate_run_q) begin
      rate_cnt_q <= rate_tick ? rate_q : rate_cnt_q - 16'h0001;
    end
  end

  // Converter answer synchronisers
  logic        done_s1, done_s2, done_s3;
  logic [15:0] res_s1, res_s2;
  logic        conv_fin;
  assign conv_fin = done_s2 & ~done_s3;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      {done_s1, done_s2, done_s3} <= 3'h0;
      res_s1 <= 16'h0000;
      res_s2 <= 16'h0000;
    end else begin
      {done_s1, done_s2, done_s3} <= {DONE_STATUS, done_s1, done_s2};
      res_s1 <= CONV_RESULT;
      res_s2 <= res_s1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer
  logic       trig;
  logic [1:0] slot_q;
  logic [1:0] last_slot;
  logic [3:0] cyc_q;
  logic       seq_end;
  always_comb begin
    case (tsel_q)
      TRIG_SOFT: trig = start_one;
      TRIG_RISE: trig = PWM_RISE;
      TRIG_FALL: trig = PWM_FALL;
      TRIG_PER:  trig = PWM_PERIOD;
      TRIG_RATE: trig = rate_tick;
      default:   trig = 1'b0;
    endcase
  end
  assign last_slot = (seqlen_q == 3'h0) ? 2'h0 : (seqlen_q >= 3'h4) ? 2'h3 : 2'(seqlen_q - 3'h1);
  assign seq_end = (state_q == ST_CONV) & conv_fin & (slot_q == last_slot);

  always_ff @(posedge MCLK) begin
    if (RST || dig_rst_q || !conv_en_q) begin
      state_q    <= ST_IDLE;
      slot_q     <= 2'h0;
      cyc_q      <= 4'h0;
      CONV_START <= 1'b0;
    end else begin
      CONV_START <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (trig) begin
            state_q <= ST_DELAY;
            slot_q  <= 2'h0;
            cyc_q   <= tdly_q;
          end
        end
        ST_DELAY: begin
          if (tick) begin
            if (cyc_q == 4'h0) begin
              state_q <= ST_SAMPLE;
              cyc_q   <= samp_q;
            end else begin
              cyc_q <= cyc_q - 4'h1;
            end
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (cyc_q == 4'h0) begin
              state_q    <= ST_CONV;
              CONV_START <= 1'b1;
            end else begin
              cyc_q <= cyc_q - 4'h1;
            end
          end
        end
        ST_CONV: begin
          if (conv_fin) begin
            cyc_q <= samp_q;
            if (slot_q != last_slot) begin
              slot_q  <= slot_q + 2'h1;
              state_q <= ST_SAMPLE;
            end else if (repeat_q) begin
              slot_q  <= 2'h0;
              state_q <= ST_SAMPLE;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Results stored per slot
  always_ff @(posedge MCLK) begin
    if (RST || dig_rst_q) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        result_q[i] <= 16'h0000;
      end
    end else if (state_q == ST_CONV && conv_fin) begin
      result_q[slot_q] <= res_s2;
    end
  end

  // Done status and interrupt flag; set beats clear
  always_ff @(posedge MCLK) begin
    if (RST || dig_rst_q) begin
      done_q  <= 1'b0;
      iflag_q <= 1'b0;
    end else begin
      if (seq_end) begin
        done_q <= 1'b1;
      end else if (trig && state_q == ST_IDLE) begin
        done_q <= 1'b0;
      end
      if (seq_end) begin
        iflag_q <= 1'b1;
      end else if (iclr_q) begin
        iflag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Analog side outputs and interrupt output
  always_ff @(posedge MCLK) begin
    if (RST) begin
      AFE_CFG      <= '{gain: RST_GAIN, input_mode: RST_MODE, default: 1'b0};
      INPUT_SELECT <= 5'h00;
      SAMPLE       <= 1'b0;
      DIG_RESET    <= 1'b0;
      IRQ          <= 1'b0;
    end else begin
      AFE_CFG      <= '{gain: gain_q, input_mode: mode_q, fe_enable: fe_en_q, ext_cm: ext_cm_q,
                        batt_scale: batt_q, conv_enable: conv_en_q};
      INPUT_SELECT <= slot_sel_q[slot_q];
      SAMPLE       <= state_q == ST_SAMPLE;
      DIG_RESET    <= dig_rst_q;
      IRQ          <= iflag_q & iena_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_apb_wait_one: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("APB answer not after one wait");
  a_digrst_self_clear: assert property (dig_rst_q |=> !dig_rst_q)
    else $error("Digital reset pulse stuck");
  a_iclr_self_clear: assert property (iclr_q |=> !iclr_q)
    else $error("Interrupt clear pulse stuck");
  a_irq_follows_flag: assert property (iflag_q && iena_q |=> IRQ)
    else $error("Interrupt not raised");
  a_done_on_end: assert property (seq_end && !dig_rst_q |=> done_q && iflag_q)
    else $error("Done not set at sequence end");
  a_single_idle: assert property (seq_end && !repeat_q && conv_en_q && !dig_rst_q |=> state_q == ST_IDLE)
    else $error("Single pass did not return to idle");
  a_repeat_restart: assert property (seq_end && repeat_q && conv_en_q && !dig_rst_q |=> state_q == ST_SAMPLE && slot_q == 2'h0)
    else $error("Repeat sequence did not restart");
  a_soft_start: assert property (state_q == ST_IDLE && conv_en_q && tsel_q == TRIG_SOFT && start_one && !dig_rst_q
                                 |=> state_q == ST_DELAY && cyc_q == tdly_q)
    else $error("Software start ignored");
  a_divider_reset: assert property ($fell(RST) |-> clkdiv_q == RST_CLKDIV && gain_q == RST_GAIN)
    else $error("Divider reset value wrong");
  a_busy_read: assert property (setup_acc && !PWRITE && hit(PADDR, ADDR_CONTROL) |=> PRDATA[POS_START] == $past(busy))
    else $error("Start bit does not show busy");

  c_single_seq: cover property (seq_end && !repeat_q);
  c_repeat_seq: cover property (seq_end && repeat_q);
  c_rate_trig: cover property (rate_tick && state_q == ST_IDLE);
  c_set_clear: cover property (seq_end && iclr_q);
endmodule
`default_nettype wire

// ---- sar_core_model.sv ----
// Purpose: Behavioural model of the analog converter core
// Assumes: One conversion per start pulse, latency set by the bench
// Notes:   Result is scrambled once done falls
`default_nettype none
module sar_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [4:0]  sel,
  input  wire logic [3:0]  lat,
  output logic             done,
  output logic [15:0]      result
);
  timeunit 1ns;
  timeprecision 1ns;
  int         wait_q;
  int         hold_q;
  logic [4:0] code_q;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q <= 0;
      hold_q <= 0;
      code_q <= 5'h00;
      done   <= 1'b0;
      result <= 16'h5A5A;
    end else begin
      if (start) begin
        wait_q <= int'(lat) + 2;
        code_q <= sel;
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end else if (wait_q == 1) begin
        wait_q <= 0;
        done   <= 1'b1;
        result <= {11'h780, code_q};
        hold_q <= 6;
      end
      if (hold_q == 1) begin
        done   <= 1'b0;
        result <= ~result;
      end
      if (hold_q > 0) hold_q <= hold_q - 1;
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Register level tests of the converter controller
// Assumes: One wait state APB slave, converter model on the far side
// Notes:   Converter result is 0xF000 or the slot code
`default_nettype none
module testbench
  import sar_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic        PWM_RISE, PWM_FALL, PWM_PERIOD, DONE_STATUS, CONV_CLK, SAMPLE, CONV_START, DIG_RESET, IRQ;
  logic [31:0] PADDR, PWDATA, PRDATA, r, d;
  logic [15:0] CONV_RESULT;
  logic [4:0]  INPUT_SELECT;
  logic [3:0]  lat;
  afe_cfg_s    AFE_CFG;
  logic        clk_d;
  logic [4:0]  codes[$];
  logic [4:0]  exp_c[4] = '{5'h01, 5'h09, 5'h10, 5'h12};
  int          n_errors, tests_run, cyc, n_conv, n_dig, s_run, s_last, rise_c, period, n0;
  sar_adc_controller i_dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PWM_RISE(PWM_RISE), .PWM_FALL(PWM_FALL), .PWM_PERIOD(PWM_PERIOD), .DONE_STATUS(DONE_STATUS),
    .CONV_RESULT(CONV_RESULT), .AFE_CFG(AFE_CFG), .INPUT_SELECT(INPUT_SELECT), .CONV_CLK(CONV_CLK),
    .SAMPLE(SAMPLE), .CONV_START(CONV_START), .DIG_RESET(DIG_RESET), .IRQ(IRQ));
  sar_core_model i_core (.clk(MCLK), .rst(RST), .start(CONV_START), .sel(INPUT_SELECT), .lat(lat),
    .done(DONE_STATUS), .result(CONV_RESULT));
  ////////////////////////////////////////////////////////////
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    cyc++;
    if (CONV_START === 1'b1) begin
      n_conv++;
      codes.push_back(INPUT_SELECT);
    end
    if (DIG_RESET === 1'b1) n_dig++;
    if (SAMPLE === 1'b1) begin
      s_run++;
    end else if (s_run != 0) begin
      s_last = s_run;
      s_run  = 0;
    end
    if (CONV_CLK === 1'b1 && clk_d !== 1'b1) begin
      period = cyc - rise_c;
      rise_c = cyc;
    end
    clk_d = CONV_CLK;
    if (cyc > 60000) begin
      n_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] dw);
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= dw;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1) begin
      @(posedge MCLK);
    end
    r   = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, r);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] dw);
    apb(1'b1, a, dw);
  endtask
  task automatic idle_wait();
    int n;
    n = 0;
    r = 32'hFFFF_FFFF;
    while (r[POS_START] !== 1'b0 && n < 100) begin
      apb(1'b0, ADDR_CONTROL, 32'h0);
      n++;
    end
  endtask
  task automatic pwm(input logic [2:0] v);
    @(posedge MCLK);
    {PWM_PERIOD, PWM_FALL, PWM_RISE} <= v;
    @(posedge MCLK);
    {PWM_PERIOD, PWM_FALL, PWM_RISE} <= 3'h0;
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {RST, lat} = {1'b1, 4'h1};
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {PWM_RISE, PWM_FALL, PWM_PERIOD} = 3'h0;
    repeat (6) @(posedge MCLK);
    RST <= 1'b0;
    rdc("frontend", ADDR_FRONTEND, 32'h0000_4300);
    rdc("control", ADDR_CONTROL, 32'h0);
    rdc("channel", ADDR_CHANNEL, 32'h0);
    rdc("intr", ADDR_INTR, 32'h0);
    rdc("clkdiv", ADDR_CLKDIV, 32'h5);
    rdc("timing", ADDR_TIMING, 32'h0008_0007);
    chk("afe", 32'h070, {24'h0, AFE_CFG});
    apb(1'b0, 32'h5001_0D30, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, r);
    $display("reset test done");
    for (int m = 0; m < 4; m++) begin
      d = (32'(m % 2) << POS_GAIN) | (32'(m) << POS_MODE) | (32'(m / 2) << POS_FE_EN) | 32'(m % 2);
      wr(ADDR_FRONTEND, d);
      rdc("frontend", ADDR_FRONTEND, d);
      chk("afe", {24'h0, 1'b0, d[POS_GAIN], d[9:8], d[7], d[0], 2'b00}, {24'h0, AFE_CFG});
    end
    rdc("batt", ADDR_CHANNEL, 32'h0);
    wr(ADDR_CHANNEL, 32'h8000_0000);
    rdc("batt", ADDR_CHANNEL, 32'h8000_0000);
    chk("batt", 32'h1, {31'h0, AFE_CFG.batt_scale});
    wr(ADDR_CONTROL, 32'h0000_0400);
    rdc("digrst", ADDR_CONTROL, 32'h0);
    chk("digrst", 32'h1, 32'(n_dig));
    wr(ADDR_TIMING, 32'h0000_0103);
    wr(ADDR_CHANNEL, 32'h0000_0009);
    wr(ADDR_CONTROL, 32'h0001_0000);
    repeat (60) @(posedge MCLK);
    chk("disabled", 32'h0, 32'(n_conv));
    $display("config test done");
    lat = 4'hC;
    wr(ADDR_CHANNEL, 32'h1210_090C);
    wr(ADDR_INTR, 32'h1);
    wr(ADDR_CONTROL, 32'h1);
    codes.delete();
    wr(ADDR_CONTROL, 32'h0001_0001);
    rdc("busy", ADDR_CONTROL, 32'h0001_0001);
    chk("afe en", 32'h1, {31'h0, AFE_CFG.conv_enable});
    idle_wait();
    repeat (3) @(posedge MCLK);
    chk("irq", 32'h1, {31'h0, IRQ});
    chk("slots", 32'h4, 32'(n_conv));
    for (int i = 0; i < 4; i++) begin
      chk("code", {27'h0, exp_c[i]}, {27'h0, codes[i]});
      rdc("result", ADDR_RESULT0 + 32'(4 * i), {16'h0, 11'h780, exp_c[i]});
    end
    rdc("intr", ADDR_INTR, 32'h0101_0001);
    wr(ADDR_INTR, 32'h0);
    rdc("masked", ADDR_INTR, 32'h0101_0000);
    chk("irq masked", 32'h0, {31'h0, IRQ});
    wr(ADDR_INTR, 32'h100);
    rdc("cleared", ADDR_INTR, 32'h0001_0000);
    $display("sequence test done");
    lat = 4'h1;
    wr(ADDR_CHANNEL, 32'h0000_0049);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_TIMING, 32'h0000_0003 | (32'h200 << k));
      n0 = n_conv;
      pwm(3'h7 & ~(3'h1 << k));
      repeat (60) @(posedge MCLK);
      chk("pwm other", 32'(n0), 32'(n_conv));
      pwm(3'h1 << k);
      repeat (60) @(posedge MCLK);
      chk("pwm", 32'(n0 + 1), 32'(n_conv));
      chk("sample", 32'd20, 32'(s_last));
    end
    chk("period", 32'h5, 32'(period));
    wr(ADDR_CLKDIV, 32'h8);
    repeat (30) @(posedge MCLK);
    chk("period", 32'h8, 32'(period));
    wr(ADDR_CLKDIV, 32'h5);
    $display("trigger test done");
    wr(ADDR_RATE, 32'h3F);
    wr(ADDR_TIMING, 32'h0000_0003);
    n0 = n_conv;
    wr(ADDR_CONTROL, 32'h0001_0001);
    repeat (300) @(posedge MCLK);
    chk("rate", 32'h1, {31'h0, n_conv - n0 >= 3});
    wr(ADDR_CONTROL, 32'h1);
    repeat (100) @(posedge MCLK);
    n0 = n_conv;
    repeat (200) @(posedge MCLK);
    chk("rate stop", 32'(n0), 32'(n_conv));
    wr(ADDR_TIMING, 32'h0000_0103);
    wr(ADDR_CHANNEL, 32'h0000_0A4A);
    n0 = n_conv;
    wr(ADDR_CONTROL, 32'h0005_0001);
    repeat (400) @(posedge MCLK);
    chk("repeat", 32'h1, {31'h0, n_conv - n0 > 2});
    rdc("repeat busy", ADDR_CONTROL, 32'h0005_0001);
    wr(ADDR_CONTROL, 32'h0000_0401);
    repeat (20) @(posedge MCLK);
    n0 = n_conv;
    repeat (100) @(posedge MCLK);
    chk("abort", 32'(n0), 32'(n_conv));
    idle_wait();
    chk("abort idle", 32'h0, {31'h0, r[POS_START]});
    $display("repeat test done");
    summarize();
  end
endmodule
`default_nettype wire
